// ---- inc/rsc_pkg.sv ----
// package: register map, field layout, reset values and types of the reset source control
package rsc_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [3:0] RSC_CTRL_OFS   = 4'h0; // reset_bypass_control
  localparam logic [3:0] RSC_STAT_OFS   = 4'h4; // power-down / time-out flags
  localparam logic [3:0] RSC_IRQS_OFS   = 4'h8; // sticky reset event status
  localparam logic [3:0] RSC_IRQE_OFS   = 4'hC; // reset event interrupt enable
  localparam logic [4:0] RSC_IRQC_ADDR  = 5'h10; // write-only event clear

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int RSC_BYPASS_BIT  = 4;  // usb_reset_bypass in control reg
  localparam int RSC_WBCLR_BIT   = 0;  // write_buffer_clear in control reg
  localparam int RSC_PDF_BIT     = 0;  // power_down_flag in status reg
  localparam int RSC_TOF_BIT     = 1;  // timeout_flag in status reg
  localparam int RSC_NEVT        = 5;  // number of reset event sources

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RSC_CTRL_RST  = 8'h00;
  localparam logic [7:0] RSC_CTRL_MASK = 8'h11; // implemented bits 4 and 0
  localparam logic [4:0] RSC_IRQE_RST  = 5'h00;
  localparam logic [7:0] RSC_SP_TOP    = 8'h07; // top-of-stack index
  localparam logic [7:0] RSC_ZERO8     = 8'h00;
  localparam logic [7:0] RSC_PORT_IN   = 8'hFF; // all pins as inputs
  localparam logic [1:0] RSC_PULSE_CYC = 2'h3;  // reset pulse length minus one, cycles

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  // reset sources, as single-cycle requests after synchronising
  typedef struct packed {
    logic usb;      // usb_serial_engine saw a bus reset
    logic wdt;      // watchdog_timer time-out
    logic low_voltage_reset;      // low_voltage_reset
    logic ext;      // external_reset_pin
    logic por;      // power-on reset
  } rsc_src_t;

  // power state of the core
  typedef enum logic [1:0] {
    RSC_MODE_NORMAL = 2'b00,
    RSC_MODE_SLOW   = 2'b01,
    RSC_MODE_IDLE   = 2'b11,
    RSC_MODE_SLEEP  = 2'b10
  } rsc_mode_t;

  // kind of reset applied to the core
  typedef enum logic [1:0] {
    RSC_RK_FULL = 2'b00, // power-on: everything to defined state
    RSC_RK_WARM = 2'b01, // pin, lvr, usb or normal-mode watchdog
    RSC_RK_WAKE = 2'b11  // watchdog in idle/sleep: pc and sp only
  } rsc_kind_t;

  // sequencer states, gray from run to hold to release, not from release back to run
  typedef enum logic [1:0] {
    RSC_ST_RUN  = 2'b00,
    RSC_ST_HOLD = 2'b01,
    RSC_ST_REL  = 2'b11
  } rsc_state_t;

  // reset commands to the rest of the chip
  typedef struct packed {
    logic       core_rst;   // core held in reset
    logic       pc_clr;     // program counter to zero
    logic       sp_clr;     // stack pointer to zero
    logic       sp_top;     // stack pointer to top
    logic       irq_off;    // all interrupts disabled
    logic       wdt_clr;    // watchdog counter cleared, then runs
    logic       tmr_off;    // timer/event counter switched off
    logic       io_input;   // all port pins to input
  } rsc_cmd_t;

endpackage

// ---- rtl/rsc_sync.sv ----
// two-stage synchroniser for a vector of asynchronous reset requests
`timescale 1ns/1ps
`default_nettype none
module rsc_sync
#(
  parameter int W = 4
)
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  // ----------------------------------------------------------------------
  // synchroniser stages
  // ----------------------------------------------------------------------
  logic [W-1:0] meta_reg; // first stage, read only by the second stage

  // one chain per bit, so no bit waits on another
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- rtl/rsc_top.sv ----
// reset source control: usb bypass, reset flags, power-on defaults
// Operation
// - bypass 0: usb reset gives warm reset
// - bypass 1: usb reset ignored, mcu runs
// - power-on reset ignores the bypass bit
// - bypass at bit 4, clear at bit 0, others zero
// - flags in status, cleared by power-on
// - pin, lvr, usb reset keep flags
// - normal watchdog reset sets time-out only
// - idle/sleep watchdog reset sets both flags
// - power-on disables every interrupt
// - power-on clears watchdog, then counts
// - power-on switches timer counter off
// - power-on makes every port pin input
// - power-on puts stack pointer at top
// - any reset clears program counter
// - idle watchdog clears pc and sp only
`timescale 1ns/1ps
`default_nettype none
module rsc_top
  import rsc_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst,          // power-on reset, sync
  input  wire logic               ext_rst_n,    // external_reset_pin, low
  input  wire logic               lvr_req,      // low_voltage_reset, async
  input  wire logic               wdt_req,      // watchdog time-out, async
  input  wire logic               usb_req,      // usb_serial_engine reset
  input  wire rsc_mode_t          mode,         // core power mode, clocked
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [4:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output var  logic [31:0]        wb_dat_o,
  output var  logic               wb_ack_o,
  output var  rsc_cmd_t           cmd,          // reset commands
  output var  logic [7:0]         pc_value,     // program counter on reset
  output var  logic [7:0]         sp_value,     // stack pointer on reset
  output var  logic [7:0]         port_dir,     // 1 = pin is input
  output var  logic               power_down_flag,
  output var  logic               timeout_flag,
  output var  logic               wb_clear_pulse, // write_buffer_clear
  output var  logic               irq
);

  // ----------------------------------------------------------------------
  // synchronised reset sources
  // ----------------------------------------------------------------------
  logic [3:0]  src_sync;      // ext, lvr, wdt, usb after two flops
  logic [3:0]  src_prev_reg;  // for rising-edge detection
  logic [3:0]  src_rise;      // one-cycle request per source
  logic        por_q_reg;     // power-on seen in last cycle

  rsc_sync #(.W(4)) u_sync
  (
    .clock    (clock),
    .rst      (rst),
    .async_in ({~ext_rst_n, lvr_req, wdt_req, usb_req}),
    .sync_out (src_sync)
  );

  // edge detect on the second stage only
  always_ff @(posedge clock)
  begin
    if (rst)
      src_prev_reg <= 4'h0;
    else
      src_prev_reg <= src_sync;
  end

  assign src_rise = src_sync & ~src_prev_reg;

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  logic [7:0]  ctrl_reg;      // reset_bypass_control
  logic        usb_reset_bypass;
  logic        wb_hit;        // new request this cycle
  logic        wr_ctrl;
  logic        wr_ien;
  logic        wr_clr;

  assign wb_hit  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = wb_hit && wb_we_i && wb_sel_i[0]
                   && (wb_adr_i == {1'b0, RSC_CTRL_OFS});
  assign wr_ien  = wb_hit && wb_we_i && wb_sel_i[0]
                   && (wb_adr_i == {1'b0, RSC_IRQE_OFS});
  assign wr_clr  = wb_hit && wb_we_i && wb_sel_i[0]
                   && (wb_adr_i == RSC_IRQC_ADDR);
  assign usb_reset_bypass = ctrl_reg[RSC_BYPASS_BIT];

  // only power-on or a control write clears the bypass bit; other resets leave it alone
  always_ff @(posedge clock)
  begin
    if (rst)
      ctrl_reg <= RSC_CTRL_RST;
    else if (wr_ctrl)
      ctrl_reg <= wb_dat_i[7:0] & RSC_CTRL_MASK;
  end

  // write_buffer_clear gives a one-cycle strobe; bit 0 also stays stored in ctrl_reg
  always_ff @(posedge clock)
  begin
    if (rst)
      wb_clear_pulse <= 1'b0;
    else
      wb_clear_pulse <= wr_ctrl && wb_dat_i[RSC_WBCLR_BIT];
  end

  // ----------------------------------------------------------------------
  // reset decision
  // ----------------------------------------------------------------------
  logic        usb_take;      // usb request that is not bypassed
  logic        any_req;
  logic        low_power;
  rsc_kind_t   kind_next;

  assign usb_take  = src_rise[0] && !usb_reset_bypass;
  assign any_req   = src_rise[3] || src_rise[2] || src_rise[1] || usb_take;
  assign low_power = (mode == RSC_MODE_IDLE) || (mode == RSC_MODE_SLEEP);

  always_comb
  begin
    if (src_rise[1] && low_power)
      kind_next = RSC_RK_WAKE;
    else
      kind_next = RSC_RK_WARM;
  end

  // ----------------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------------
  // power-on wins; pin, lvr and usb leave the flags as they are
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      power_down_flag <= 1'b0;
      timeout_flag    <= 1'b0;
    end
    else if (src_rise[1])
    begin
      timeout_flag <= 1'b1;
      if (low_power)
        power_down_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------------
  rsc_state_t  state_reg;
  rsc_kind_t   kind_reg;
  logic [1:0]  cnt_reg;

  // holds core reset for a short pulse; new requests during it are ignored
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= RSC_ST_HOLD;
      kind_reg  <= RSC_RK_FULL;
      cnt_reg   <= RSC_PULSE_CYC;
    end
    else
    begin
      case (state_reg)
        RSC_ST_RUN:
        begin
          if (any_req)
          begin
            state_reg <= RSC_ST_HOLD;
            kind_reg  <= kind_next;
            cnt_reg   <= RSC_PULSE_CYC;
          end
        end
        RSC_ST_HOLD:
        begin
          if (cnt_reg == 2'h0)
            state_reg <= RSC_ST_REL;
          else
            cnt_reg <= cnt_reg - 2'h1;
        end
        RSC_ST_REL:
          state_reg <= RSC_ST_RUN;
        default:
          state_reg <= RSC_ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // reset commands to the core
  // ----------------------------------------------------------------------
  logic        hold;
  logic        full;
  logic        warm;
  assign hold = (state_reg == RSC_ST_HOLD);
  assign full = hold && (kind_reg == RSC_RK_FULL);
  assign warm = hold && (kind_reg == RSC_RK_WARM);

  // a wake reset touches pc and sp only, the rest stays as it was
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cmd      <= '0;
      pc_value <= RSC_ZERO8;
      sp_value <= RSC_SP_TOP;
      port_dir <= RSC_PORT_IN;
    end
    else
    begin
      cmd.core_rst <= hold;
      cmd.pc_clr   <= hold;
      cmd.sp_clr   <= hold && (kind_reg == RSC_RK_WAKE);
      cmd.sp_top   <= full || warm;
      cmd.irq_off  <= full || warm;
      cmd.wdt_clr  <= full || warm;
      cmd.tmr_off  <= full || warm;
      cmd.io_input <= full || warm;
      if (hold)
      begin
        pc_value <= RSC_ZERO8;
        if (kind_reg == RSC_RK_WAKE)
          sp_value <= RSC_ZERO8;
        else
          sp_value <= RSC_SP_TOP;
        if (kind_reg != RSC_RK_WAKE)
          port_dir <= RSC_PORT_IN;
      end
    end
  end

  // ----------------------------------------------------------------------
  // reset event interrupts
  // ----------------------------------------------------------------------
  logic [4:0]  evt;
  logic [4:0]  ists_reg;
  logic [4:0]  ien_reg;

  // bit order: por, ext, lvr, wdt, usb (usb even when bypassed)
  assign evt = {por_q_reg, src_rise[3], src_rise[2], src_rise[1], src_rise[0]};

  always_ff @(posedge clock)
  begin
    if (rst)
      por_q_reg <= 1'b1;
    else
      por_q_reg <= 1'b0;
  end

  // set beats clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      ists_reg <= '0;
    else if (wr_clr)
      ists_reg <= (ists_reg & ~wb_dat_i[4:0]) | evt;
    else
      ists_reg <= ists_reg | evt;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      ien_reg <= RSC_IRQE_RST;
    else if (wr_ien)
      ien_reg <= wb_dat_i[4:0];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(ists_reg & ien_reg);
  end

  // ----------------------------------------------------------------------
  // wishbone answer: one cycle after the strobe, unmapped reads zero
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= '0;
      if (wb_hit && !wb_we_i)
      begin
        case (wb_adr_i)
          {1'b0, RSC_CTRL_OFS}: wb_dat_o[7:0] <= ctrl_reg;
          {1'b0, RSC_STAT_OFS}: wb_dat_o[1:0] <=
                                  {timeout_flag, power_down_flag};
          {1'b0, RSC_IRQS_OFS}: wb_dat_o[4:0] <= ists_reg;
          {1'b0, RSC_IRQE_OFS}: wb_dat_o[4:0] <= ien_reg;
          default:              wb_dat_o      <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  bypass_usb_a: assert property (@(posedge clock) disable iff (rst)
    (src_rise == 4'h1 && usb_reset_bypass && state_reg == RSC_ST_RUN)
      |=> state_reg == RSC_ST_RUN)
    else $error("bypassed usb reset started a reset");
  usb_reset_a: assert property (@(posedge clock) disable iff (rst)
    (src_rise[0] && !usb_reset_bypass && state_reg == RSC_ST_RUN)
      |=> state_reg == RSC_ST_HOLD ##1 cmd.core_rst)
    else $error("usb reset not applied");
  por_flags_a: assert property (@(posedge clock)
    $fell(rst) |-> !timeout_flag && !power_down_flag
      && cmd.core_rst == 1'b0 ##1 cmd.core_rst)
    else $error("power-on did not clear flags or reset core");
  keep_flags_a: assert property (@(posedge clock) disable iff (rst)
    !src_rise[1] |=> $stable({timeout_flag, power_down_flag}))
    else $error("flags changed without watchdog reset");
  wdt_norm_a: assert property (@(posedge clock) disable iff (rst)
    (src_rise[1] && !low_power) |=> timeout_flag
      && power_down_flag == $past(power_down_flag))
    else $error("normal watchdog reset flags wrong");
  wdt_idle_a: assert property (@(posedge clock) disable iff (rst)
    (src_rise[1] && low_power) |=> timeout_flag && power_down_flag)
    else $error("idle watchdog reset flags wrong");
  pc_clear_a: assert property (@(posedge clock) disable iff (rst)
    cmd.core_rst |-> cmd.pc_clr && pc_value == 8'h00)
    else $error("pc not cleared in reset");
  wake_keep_a: assert property (@(posedge clock) disable iff (rst)
    cmd.sp_clr |-> !cmd.io_input && !cmd.irq_off
      && sp_value == 8'h00)
    else $error("wake reset touched more than pc and sp");
  ctrl_zero_a: assert property (@(posedge clock) disable iff (rst)
    (ctrl_reg & ~RSC_CTRL_MASK) == 8'h00)
    else $error("unimplemented control bits set");
  por_defs_a: assert property (@(posedge clock) disable iff (rst)
    (full ##1 1'b1) |-> cmd.irq_off && cmd.wdt_clr && cmd.tmr_off
      && cmd.io_input && cmd.sp_top)
    else $error("power-on defaults not driven");

  usb_bypassed_c: cover property (@(posedge clock) disable iff (rst)
    src_rise[0] && usb_reset_bypass);
  usb_taken_c:    cover property (@(posedge clock) disable iff (rst) usb_take);
  wdt_idle_c:     cover property (@(posedge clock) disable iff (rst)
    src_rise[1] && low_power);
  irq_c:          cover property (@(posedge clock) disable iff (rst) irq);

endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the reset source control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rsc_pkg::*;

  // ----------------------------------------------------------------------
  // stimulus rows: source, mode, bypass and the outcome they should give
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] src;  // 0 pin, 1 low voltage, 2 usb, 3 watchdog
    rsc_mode_t  md;   // power mode while the request arrives
    logic       byp;  // usb bypass bit written first
    logic       hit;  // core reset pulse expected
    logic       tof;  // time-out flag afterwards
    logic       pdn;  // power-down flag afterwards
    logic [7:0] sp;   // stack pointer afterwards
  } rsc_tb_row_t;

  logic        clock;           // 25 mhz system clock
  logic        rst;             // power-on reset
  logic        ext_rst_n;       // pin request, active low
  logic        lvr_req;         // supply monitor request
  logic        wdt_req;         // watchdog expiry
  logic        usb_req;         // usb bus reset
  rsc_mode_t   mode;            // core power mode
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [4:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  rsc_cmd_t    cmd;
  logic [7:0]  pc_value;
  logic [7:0]  sp_value;
  logic [7:0]  port_dir;
  logic        power_down_flag;
  logic        timeout_flag;
  logic        wb_clear_pulse;
  logic        irq;
  int          errors;          // mismatches seen
  int          num_checks;      // comparisons made
  int          clr_cnt = 0;     // write-buffer clear pulses seen
  logic [31:0] q;               // last read data
  rsc_tb_row_t rows [9];

  rsc_top dut (.clock(clock), .rst(rst), .ext_rst_n(ext_rst_n),
    .lvr_req(lvr_req), .wdt_req(wdt_req), .usb_req(usb_req), .mode(mode),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd(cmd),
    .pc_value(pc_value), .sp_value(sp_value), .port_dir(port_dir),
    .power_down_flag(power_down_flag), .timeout_flag(timeout_flag),
    .wb_clear_pulse(wb_clear_pulse), .irq(irq));

  // free-running clock, 40 ns period
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // count clear strobes so a missing or doubled pulse shows up
  always @(posedge clock)
  begin
    if (wb_clear_pulse === 1'b1)
      clr_cnt <= clr_cnt + 1;
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic test_done;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    begin
      num_checks++;
      if (g !== e)
      begin
        errors++;
        $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // one classic cycle; waits for ack under a bound, data taken at that edge
  task automatic wb(input logic we, input logic [4:0] a,
                    input logic [31:0] d);
    int n;
    begin
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      n = 0;
      do
      begin
        @(posedge clock);
        n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (n >= 20)
      begin
        errors++;
        $display("unexpected ack: expected 1 seen timeout");
        test_done();
      end
    end
  endtask

  // raise or drop one reset request line
  task automatic drive(input logic [1:0] s, input logic on);
    begin
      case (s)
        2'd0: ext_rst_n <= ~on;
        2'd1: lvr_req <= on;
        2'd2: usb_req <= on;
        default: wdt_req <= on;
      endcase
    end
  endtask

  // power-on pulse: every default command, then quiet, all flags clear
  task automatic por_check;
    logic [7:0] acc;
    begin
      acc = 8'h00;
      repeat (8)
      begin
        @(posedge clock);
        #1 acc = acc | cmd;
      end
      check("power-on cmd", 32'hDF,
            {24'h0, acc});
      check("cmd idle", 32'h0, {24'h0, cmd});
      check("pc", 32'h0, {24'h0, pc_value});
      check("sp", {24'h0, RSC_SP_TOP}, {24'h0, sp_value});
      check("port_dir", {24'h0, RSC_PORT_IN}, {24'h0, port_dir});
      check("flags", 32'h0,
            {30'h0, timeout_flag, power_down_flag});
      wb(1'b0, {1'b0, RSC_CTRL_OFS}, 32'h0);
      check("ctrl", {24'h0, RSC_CTRL_RST}, q);
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rst <= 1'b1;
    ext_rst_n <= 1'b1;
    lvr_req <= 1'b0;
    wdt_req <= 1'b0;
    usb_req <= 1'b0;
    mode <= RSC_MODE_NORMAL;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_adr_i <= 5'h00;
    wb_sel_i <= 4'h0;
    wb_dat_i <= 32'h0;
    errors = 0;
    num_checks = 0;
    // flags accumulate from row to row, so order matters
    rows[0] = {2'd0, RSC_MODE_NORMAL, 1'b0, 1'b1, 1'b0, 1'b0, 8'h07};
    rows[1] = {2'd1, RSC_MODE_SLOW,   1'b0, 1'b1, 1'b0, 1'b0, 8'h07};
    rows[2] = {2'd2, RSC_MODE_NORMAL, 1'b0, 1'b1, 1'b0, 1'b0, 8'h07};
    rows[3] = {2'd2, RSC_MODE_NORMAL, 1'b1, 1'b0, 1'b0, 1'b0, 8'h07};
    rows[4] = {2'd3, RSC_MODE_NORMAL, 1'b0, 1'b1, 1'b1, 1'b0, 8'h07};
    rows[5] = {2'd0, RSC_MODE_SLOW,   1'b0, 1'b1, 1'b1, 1'b0, 8'h07};
    rows[6] = {2'd3, RSC_MODE_IDLE,   1'b0, 1'b1, 1'b1, 1'b1, 8'h00};
    rows[7] = {2'd3, RSC_MODE_SLEEP,  1'b0, 1'b1, 1'b1, 1'b1, 8'h00};
    rows[8] = {2'd2, RSC_MODE_NORMAL, 1'b0, 1'b1, 1'b1, 1'b1, 8'h07};
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    por_check();

    // table of reset sources, each row in one of the four power modes
    foreach (rows[i])
    begin
      logic       hit;
      logic [7:0] seen;     // every command bit seen during the pulse
      logic [7:0] exp_cmd;  // wake: core reset, pc and sp; warm: all but sp_clr
      wb(1'b1, {1'b0, RSC_CTRL_OFS}, {27'h0, rows[i].byp, 4'h0});
      mode <= rows[i].md;
      @(posedge clock);
      drive(rows[i].src, 1'b1);
      hit = 1'b0;
      seen = 8'h00;
      repeat (14)
      begin
        @(posedge clock);
        #1 hit = hit | cmd.core_rst;
        seen = seen | cmd;
      end
      drive(rows[i].src, 1'b0);
      repeat (6) @(posedge clock);
      #1;
      check("core reset", {31'h0, rows[i].hit},
            {31'h0, hit});
      check("timeout_flag", {31'h0, rows[i].tof},
            {31'h0, timeout_flag});
      check("power_down_flag", {31'h0, rows[i].pdn},
            {31'h0, power_down_flag});
      check("sp", {24'h0, rows[i].sp}, {24'h0, sp_value});
      check("pc", 32'h0, {24'h0, pc_value});
      exp_cmd = (rows[i].sp == 8'h00) ? 8'hE0 : 8'hDF;
      exp_cmd = rows[i].hit ? exp_cmd : 8'h00;
      check("cmd", {24'h0, exp_cmd}, {24'h0, seen});
      wb(1'b0, {1'b0, RSC_STAT_OFS}, 32'h0);
      check("status", {30'h0, rows[i].tof, rows[i].pdn}, q);
    end

    // control register: only bypass and clear strobe are kept
    wb(1'b1, {1'b0, RSC_CTRL_OFS}, 32'hFFFFFFFF);
    wb(1'b0, {1'b0, RSC_CTRL_OFS}, 32'h0);
    check("ctrl mask", {24'h0, RSC_CTRL_MASK}, q);
    repeat (2) @(posedge clock);
    check("clear pulses", 32'h1, clr_cnt);
    wb(1'b0, 5'h14, 32'h0);
    check("unmapped", 32'h0, q);

    // sticky events, enable, mask and clear of the interrupt
    wb(1'b0, {1'b0, RSC_IRQS_OFS}, 32'h0);
    check("events", 32'h1F, q);
    wb(1'b1, {1'b0, RSC_IRQE_OFS}, 32'h2);
    repeat (2) @(posedge clock);
    #1 check("irq on", 32'h1, {31'h0, irq});
    wb(1'b1, {1'b0, RSC_IRQE_OFS}, 32'h0);
    repeat (2) @(posedge clock);
    #1 check("irq masked", 32'h0, {31'h0, irq});
    wb(1'b1, {1'b0, RSC_IRQE_OFS}, 32'h2);
    wb(1'b1, RSC_IRQC_ADDR, 32'h1F);
    repeat (2) @(posedge clock);
    #1 check("irq cleared", 32'h0, {31'h0, irq});
    wb(1'b0, {1'b0, RSC_IRQS_OFS}, 32'h0);
    check("events cleared", 32'h0, q);

    // power-on in mid-run with bypass set still resets everything
    wb(1'b1, {1'b0, RSC_CTRL_OFS}, 32'h10);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    por_check();
    test_done();
  end

  // hang guard far above the few hundred cycles the test needs
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    $display("unexpected run length: expected end seen timeout");
    test_done();
  end
endmodule
`default_nettype wire
